/* pkg/ssr_defines.svh */
`ifndef SSR_DEFINES_SVH
`define SSR_DEFINES_SVH
`define SSR_CLK_HZ 50000000
`define SSR_RST_MS 130
`define SSR_NMI_US 200
`define SSR_NMI_FILT_US 5
`define SSR_GLITCH_US 2
`define SSR_WDT_MS 1000
`define SSR_DEB_US 1000
`define SSR_RST_CYC ((`SSR_CLK_HZ / 1000) * `SSR_RST_MS)
`define SSR_NMI_CYC ((`SSR_CLK_HZ / 1000000) * `SSR_NMI_US)
`define SSR_NMI_FILT_CYC ((`SSR_CLK_HZ / 1000000) * `SSR_NMI_FILT_US)
`define SSR_GLITCH_CYC ((`SSR_CLK_HZ / 1000000) * `SSR_GLITCH_US)
`define SSR_WDT_CYC ((`SSR_CLK_HZ / 1000) * `SSR_WDT_MS)
`define SSR_DEB_CYC ((`SSR_CLK_HZ / 1000000) * `SSR_DEB_US)
`endif

/* pkg/ssr_pkg.sv */
package ssr_pkg;
   typedef enum logic [1:0] {
      SSR_RUN = 2'b00,
      SSR_HOLD = 2'b01,
      SSR_STRETCH = 2'b10
   } ssr_rst_state_t;
endpackage : ssr_pkg

/* design/ssr_filter.sv */
`timescale 1ns/1ps
// Three-stage synchroniser followed by a persistence filter: the output
// takes a new level only after the input held it for HOLD_CYC cycles.
module ssr_filter #(
   parameter int HOLD_CYC = 100,
   parameter logic INIT = 1'b1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Raw level and filtered level
   input wire logic raw,
   output logic level
);
   typedef struct packed {
      logic [2:0] sync;
      logic [31:0] cnt;
      logic lvl;
   } ssr_filt_t;
   ssr_filt_t s_r;
   ssr_filt_t s_nxt;
   logic agreed;

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.sync = {s_r.sync[1:0], raw};
      agreed = s_r.sync[2];
      if (s_r.sync[1] == s_r.sync[2])
      begin
         agreed = s_r.sync[2];
      end
      else
      begin
         agreed = s_r.lvl;
      end
      if (agreed == s_r.lvl)
      begin
         s_nxt.cnt = 32'h00000000;
      end
      else if (s_r.cnt >= 32'(HOLD_CYC - 1))
      begin
         s_nxt.lvl = agreed;
         s_nxt.cnt = 32'h00000000;
      end
      else
      begin
         s_nxt.cnt = s_r.cnt + 32'h00000001;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         s_r <= {{3{INIT}}, 32'h00000000, INIT};
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign level = s_r.lvl;
endmodule : ssr_filter

/* design/ssr_supervisor.sv */
`timescale 1ns/1ps
`include "ssr_defines.svh"
module ssr_supervisor #(
   parameter int RST_CYC = `SSR_RST_CYC,
   parameter int NMI_CYC = `SSR_NMI_CYC,
   parameter int NMI_FILT_CYC = `SSR_NMI_FILT_CYC,
   parameter int GLITCH_CYC = `SSR_GLITCH_CYC,
   parameter int WDT_CYC = `SSR_WDT_CYC,
   parameter int DEB_CYC = `SSR_DEB_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Comparator and button inputs
   input wire logic supply_fail,
   input wire logic sense_low,
   input wire logic button_reset_n,
   // Watchdog kick from the processor
   input wire logic kick_edge,
   // Outputs to the processor
   output logic reset_n,
   output logic reset,
   output logic warning_n,
   output logic watchdog_status_n
);
   typedef struct packed {
      ssr_pkg::ssr_rst_state_t st;
      logic [31:0] rst_cnt;
      logic [31:0] wdt_cnt;
      logic [31:0] wds_cnt;
      logic [31:0] nmi_cnt;
      logic [2:0] kick_sync;
      logic kick_lvl;
      logic sense_q;
      logic rst_n;
      logic rst;
      logic nmi_n;
      logic wds_n;
   } ssr_state_t;
   ssr_state_t s_r;
   ssr_state_t s_nxt;
   logic fail_f;
   logic sense_f;
   logic button_f;
   logic kick_fall;

   // Either source holds reset; the run and the stretch state both ask.
   function automatic logic rst_wanted(input logic fail, input logic btn);
      return fail || !btn;
   endfunction : rst_wanted

   // Pulse counters run down to zero and rest there.
   function automatic logic [31:0] count_down(input logic [31:0] c);
      logic [31:0] r;
      r = c;
      if (c != 32'h00000000)
      begin
         r = c - 32'h00000001;
      end
      return r;
   endfunction : count_down

   ssr_filter #(.HOLD_CYC(GLITCH_CYC), .INIT(1'b1)) u_fail (
      .clk(clk),
      .resetn(resetn),
      .raw(supply_fail),
      .level(fail_f)
   );

   ssr_filter #(.HOLD_CYC(NMI_FILT_CYC), .INIT(1'b0)) u_sense (
      .clk(clk),
      .resetn(resetn),
      .raw(sense_low),
      .level(sense_f)
   );

   ssr_filter #(.HOLD_CYC(DEB_CYC), .INIT(1'b1)) u_button (
      .clk(clk),
      .resetn(resetn),
      .raw(button_reset_n),
      .level(button_f)
   );

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.kick_sync = {s_r.kick_sync[1:0], kick_edge};
      kick_fall = 1'b0;
      // A one-cycle glitch never makes the last two stages agree, so a
      // kick counts only once it has settled.
      if (s_r.kick_sync[1] == s_r.kick_sync[2])
      begin
         s_nxt.kick_lvl = s_r.kick_sync[2];
         if (s_r.kick_lvl && !s_r.kick_sync[2])
         begin
            kick_fall = 1'b1;
         end
      end
      // Reset waits in its own state until both sources are quiet, so the
      // stretch count always starts from the last release.
      case (s_r.st)
         ssr_pkg::SSR_RUN:
         begin
            if (rst_wanted(fail_f, button_f))
            begin
               s_nxt.st = ssr_pkg::SSR_HOLD;
            end
         end
         ssr_pkg::SSR_HOLD:
         begin
            if (!fail_f && button_f)
            begin
               s_nxt.st = ssr_pkg::SSR_STRETCH;
               s_nxt.rst_cnt = 32'h00000000;
            end
         end
         ssr_pkg::SSR_STRETCH:
         begin
            if (rst_wanted(fail_f, button_f))
            begin
               s_nxt.st = ssr_pkg::SSR_HOLD;
            end
            else if (s_r.rst_cnt >= 32'(RST_CYC - 1))
            begin
               s_nxt.st = ssr_pkg::SSR_RUN;
            end
            else
            begin
               s_nxt.rst_cnt = s_r.rst_cnt + 32'h00000001;
            end
         end
         default:
         begin
            s_nxt.st = ssr_pkg::SSR_HOLD;
         end
      endcase
      s_nxt.rst_n = (s_nxt.st == ssr_pkg::SSR_RUN);
      s_nxt.rst = (s_nxt.st != ssr_pkg::SSR_RUN);

      // The timeout that starts the status pulse also restarts timing, so a hung processor sees
      // the status output pulse again every period.
      // status low 130 ms
      s_nxt.wds_cnt = count_down(s_r.wds_cnt);
      if (s_r.st != ssr_pkg::SSR_RUN)
      begin
         s_nxt.wdt_cnt = 32'h00000000;
      end
      else if (kick_fall)
      begin
         s_nxt.wdt_cnt = 32'h00000000;
      end
      else if (s_r.wdt_cnt >= 32'(WDT_CYC - 1))
      begin
         s_nxt.wdt_cnt = 32'h00000000;
         s_nxt.wds_cnt = 32'(RST_CYC);
      end
      else
      begin
         s_nxt.wdt_cnt = s_r.wdt_cnt + 32'h00000001;
      end
      s_nxt.wds_n = (s_nxt.wds_cnt == 32'h00000000);

      // Edge on the filtered sense level so one dip gives one pulse.
      s_nxt.sense_q = sense_f;
      // A dip that begins while the supply is failed gives no pulse later.
      // suppressed while supply low
      if (sense_f && !s_r.sense_q && !fail_f)
      begin
         s_nxt.nmi_cnt = 32'(NMI_CYC);
      end
      else
      begin
         s_nxt.nmi_cnt = count_down(s_r.nmi_cnt);
      end
      s_nxt.nmi_n = (s_nxt.nmi_cnt == 32'h00000000);
   end

   // Reset values model a failed supply, so reset is out from the first edge.
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         s_r.st <= ssr_pkg::SSR_HOLD;
         s_r.rst_cnt <= 32'h00000000;
         s_r.wdt_cnt <= 32'h00000000;
         s_r.wds_cnt <= 32'h00000000;
         s_r.nmi_cnt <= 32'h00000000;
         s_r.kick_sync <= 3'h7;
         s_r.kick_lvl <= 1'b1;
         s_r.sense_q <= 1'b0;
         s_r.rst_n <= 1'b0;
         s_r.rst <= 1'b1;
         s_r.nmi_n <= 1'b1;
         s_r.wds_n <= 1'b1;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // Outputs come straight from the state register.
   assign reset_n = s_r.rst_n;
   assign reset = s_r.rst;
   assign warning_n = s_r.nmi_n;
   assign watchdog_status_n = s_r.wds_n;
endmodule : ssr_supervisor

/* test/ssr_props.sv */
`timescale 1ns/1ps
module ssr_props #(
   parameter int RST_CYC = 20,
   parameter int WDT_CYC = 50
) (
   // Clock
   input wire logic clk,
   input wire logic resetn,
   // Inputs
   input wire logic supply_fail,
   input wire logic sense_low,
   input wire logic button_reset_n,
   input wire logic kick_edge,
   // Outputs
   input wire logic reset_n,
   input wire logic reset,
   input wire logic warning_n,
   input wire logic watchdog_status_n
);
   int lo_r;
   int hi_r;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // Counters start clean at reset so their values are never unknown.
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         lo_r <= 0;
         hi_r <= 0;
      end
      else
      begin
         lo_r <= reset_n ? 0 : lo_r + 1;
         hi_r <= reset_n ? hi_r + 1 : 0;
      end
   end
   sequence s_low9;
      !warning_n[*8] ##1 !warning_n ##1 warning_n;
   endsequence
   property p_pair;
      reset == !reset_n;
   endproperty
   property p_fail;
      supply_fail[*8] |-> !reset_n;
   endproperty
   property p_hold;
      $rose(reset_n) |-> lo_r >= RST_CYC;
   endproperty
   property p_wlen;
      $fell(warning_n) |=> s_low9;
   endproperty
   property p_wfilt;
      $fell(warning_n) |-> $past(sense_low, 7) && $past(sense_low, 8);
   endproperty
   property p_wsupp;
      supply_fail[*8] |-> !$fell(warning_n);
   endproperty
   property p_dgap;
      $fell(watchdog_status_n) |-> hi_r >= WDT_CYC - 2;
   endproperty
   property p_dheld;
      $fell(watchdog_status_n) |-> $past(reset_n);
   endproperty
   property p_dlen;
      $fell(watchdog_status_n) |=> !watchdog_status_n[*8];
   endproperty
   a_pair: assert property (p_pair) else $error("pair");
   a_fail: assert property (p_fail) else $error("fail");
   a_hold: assert property (p_hold) else $error("hold");
   a_wlen: assert property (p_wlen) else $error("wlen");
   a_wfilt: assert property (p_wfilt) else $error("wfilt");
   a_wsupp: assert property (p_wsupp) else $error("wsupp");
   a_dgap: assert property (p_dgap) else $error("dgap");
   a_dlen: assert property (p_dlen) else $error("dlen");
   a_dheld: assert property (p_dheld) else $error("dheld");
endmodule : ssr_props
bind ssr_supervisor ssr_props #(.RST_CYC(RST_CYC), .WDT_CYC(WDT_CYC)) u_props (
   .clk(clk),
   .resetn(resetn),
   .supply_fail(supply_fail),
   .sense_low(sense_low),
   .button_reset_n(button_reset_n),
   .kick_edge(kick_edge),
   .reset_n(reset_n),
   .reset(reset),
   .warning_n(warning_n),
   .watchdog_status_n(watchdog_status_n)
);

/* test/ssr_cpu.sv */
`timescale 1ns/1ps
module ssr_cpu (
   // Clock and control
   input wire logic clk,
   input wire logic run,
   input wire logic reset_n,
   // Kick line
   output logic kick_edge
);
   logic [3:0] cnt_r = 4'h0;
   initial kick_edge = 1'b1;
   always @(posedge clk)
   begin
      cnt_r <= cnt_r + 4'h1;
      // A halted processor stops kicking, as a hung one would.
      if (run && reset_n && cnt_r == 4'hF)
         kick_edge <= !kick_edge;
   end
endmodule : ssr_cpu

/* test/ssr_supervisor_test.sv */
`timescale 1ns/1ps
module ssr_supervisor_test;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic supply_fail = 1'b1;
   logic sense_low = 1'b0;
   logic button_reset_n = 1'b1;
   logic run = 1'b1;
   logic kick_edge, reset_n, reset, warning_n, watchdog_status_n;
   int n_mismatch = 0;
   int compares = 0;
   int n;
   ssr_supervisor #(.RST_CYC(20), .NMI_CYC(10), .NMI_FILT_CYC(4),
      .GLITCH_CYC(2), .WDT_CYC(50), .DEB_CYC(4)) dut (
      .clk(clk),
      .resetn(resetn),
      .supply_fail(supply_fail),
      .sense_low(sense_low),
      .button_reset_n(button_reset_n),
      .kick_edge(kick_edge),
      .reset_n(reset_n),
      .reset(reset),
      .warning_n(warning_n),
      .watchdog_status_n(watchdog_status_n)
   );
   ssr_cpu cpu (
      .clk(clk),
      .run(run),
      .reset_n(reset_n),
      .kick_edge(kick_edge)
   );
   initial
   begin
      forever #10 clk = !clk;
   end
   task cyc(input int k);
      repeat (k) @(posedge clk);
   endtask : cyc
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task count_low(input int k);
      n = 0;
      repeat (k)
      begin
         cyc(1);
         n += (warning_n === 1'b0) + (watchdog_status_n === 1'b0);
      end
   endtask : count_low
   task test_done;
      $display("mismatches=%0d compares=%0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done
   task t_power;
      cyc(1);
      supply_fail <= 1'b0;
      cyc(12);
      chk(reset_n, 1'b0);
      repeat (60) if (reset_n !== 1'b1) cyc(1);
      chk(reset, 1'b0);
   endtask : t_power
   task t_supply;
      supply_fail <= 1'b1;
      cyc(1);
      supply_fail <= 1'b0;
      cyc(20);
      chk(reset_n, 1'b1);
      supply_fail <= 1'b1;
      sense_low <= 1'b1;
      cyc(12);
      chk(reset_n, 1'b0);
      chk(warning_n, 1'b1);
      sense_low <= 1'b0;
      supply_fail <= 1'b0;
      cyc(40);
   endtask : t_supply
   task t_button;
      button_reset_n <= 1'b0;
      cyc(2);
      button_reset_n <= 1'b1;
      cyc(15);
      chk(reset_n, 1'b1);
      button_reset_n <= 1'b0;
      cyc(30);
      button_reset_n <= 1'b1;
      cyc(16);
      chk(reset_n, 1'b0);
      cyc(30);
      chk(reset_n, 1'b1);
   endtask : t_button
   task t_warn;
      sense_low <= 1'b1;
      cyc(2);
      sense_low <= 1'b0;
      cyc(15);
      chk(warning_n, 1'b1);
      sense_low <= 1'b1;
      count_low(30);
      chk(n, 10);
      sense_low <= 1'b0;
   endtask : t_warn
   task t_wdt;
      cyc(100);
      chk(watchdog_status_n, 1'b1);
      run <= 1'b0;
      repeat (60) if (watchdog_status_n !== 1'b0) cyc(1);
      chk(watchdog_status_n, 1'b0);
      count_low(40);
      chk(n, 19);
   endtask : t_wdt
   // The processor stays halted: the watchdog is held clear, so it must not time out inside
   // the held reset, and after release the timeout is measured from it.
   task t_hold;
      button_reset_n <= 1'b0;
      cyc(30);
      count_low(60);
      chk(n, 0);
      button_reset_n <= 1'b1;
      repeat (200) if (reset_n !== 1'b1) cyc(1);
      n = 0;
      repeat (200)
      begin
         if (watchdog_status_n !== 1'b0)
         begin
            cyc(1);
            n++;
         end
      end
      chk(n, 50);
   endtask : t_hold
   initial
   begin
      cyc(10);
      resetn <= 1'b1;
      t_power;
      t_supply;
      t_button;
      t_warn;
      t_wdt;
      t_hold;
      test_done;
   end
   initial
   begin
      #40us;
      n_mismatch++;
      test_done;
   end
endmodule : ssr_supervisor_test
